// File: core/sde_params.svh
`ifndef SDE_PARAMS_SVH
`define SDE_PARAMS_SVH

// ********************************************************************
// register map (byte addresses on the apb bus)
// ********************************************************************
`define SDE_ADDR_W      12
`define SDE_OFF_CTRL    12'h000
`define SDE_OFF_STATUS  12'h004
`define SDE_OFF_NEST    12'h008

// ********************************************************************
// control register layout and reset value
// ********************************************************************
`define SDE_CTRL_W      3
`define SDE_CTRL_RESET  3'h3
`define SDE_CTRL_BP_EN  0
`define SDE_CTRL_DBP_EN 1
`define SDE_CTRL_AUTORF 2

// ********************************************************************
// counters
// ********************************************************************
`define SDE_DEPTH_W     4
`define SDE_NEST_W      8
`define SDE_DEPTH_ONE   4'h1
`define SDE_NEST_ONE    8'h01
`define SDE_DEPTH_ZERO  4'h0
`define SDE_NEST_ZERO   8'h00
`define SDE_WORD_ZERO   32'h00000000

`endif

// File: core/sde_pkg.sv
`include "sde_params.svh"

package sde_pkg;

	// ********************************************************************
	// apb carriers
	// ********************************************************************
	typedef struct packed {
		logic                     psel;
		logic                     penable;
		logic                     pwrite;
		logic [`SDE_ADDR_W-1:0]   paddr;
		logic [31:0]              pwdata;
	} apb_in_t;

	typedef struct packed {
		logic [31:0]              prdata;
		logic                     pready;
		logic                     pslverr;
	} apb_out_t;

	// ********************************************************************
	// core pipeline events in, actions out
	// ********************************************************************
	typedef struct packed {
		logic                     nmi_req;
		logic                     resume_from_mgmt_mode;
		logic                     interrupt_return;
		logic                     popped_resume_flag;
		logic                     instr_start;
		logic                     instr_bp_match;
		logic                     instr_prefix_match;
		logic                     other_fault;
		logic                     fault_return;
		logic                     str_iter;
		logic                     string_input_op;
		logic                     str_data_match;
		logic                     str_done;
	} core_ev_t;

	typedef struct packed {
		logic                     take_smi;
		logic                     take_nmi;
		logic                     bp_fault;
		logic                     data_bp_trap;
		logic                     stacked_resume_flag;
		logic                     resume_flag;
	} core_act_t;

	typedef struct packed {
		logic [`SDE_DEPTH_W-1:0]  nmi_depth;
		logic                     spurious;
		logic                     spur_wait;
		logic                     resume_flag;
		logic                     nmi_pending;
		logic                     nmi_block;
		logic                     smi_pending;
		logic                     in_smm;
	} status_t;

endpackage

// File: core/sde_apb_regs.sv
`include "sde_params.svh"

module sde_apb_regs (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire sde_pkg::apb_in_t        apb_in,
	output sde_pkg::apb_out_t            apb_out,
	input  wire sde_pkg::status_t        status,
	input  wire logic [`SDE_NEST_W-1:0]  nest_count,
	output logic [`SDE_CTRL_W-1:0]       ctrl
);

	typedef struct packed {
		logic [`SDE_CTRL_W-1:0] ctrl;
		logic [31:0]            prdata;
	} regs_state_t;

	regs_state_t st;
	regs_state_t next_st;

	function automatic logic is_mapped(input logic [`SDE_ADDR_W-1:0] a);
		is_mapped = (a == `SDE_OFF_CTRL) || (a == `SDE_OFF_STATUS) || (a == `SDE_OFF_NEST);
	endfunction

	// ********************************************************************
	// read data is captured in the setup cycle so pready can stay high
	// ********************************************************************
	always_comb begin
		next_st = st;
		if (apb_in.psel && !apb_in.penable && !apb_in.pwrite) begin
			case (apb_in.paddr)
				`SDE_OFF_CTRL:   next_st.prdata = {{(32-`SDE_CTRL_W){1'b0}}, st.ctrl};
				`SDE_OFF_STATUS: next_st.prdata = 32'(status);
				`SDE_OFF_NEST:   next_st.prdata = 32'(nest_count);
				default:         next_st.prdata = `SDE_WORD_ZERO;
			endcase
		end
		if (apb_in.psel && apb_in.penable && apb_in.pwrite && apb_in.paddr == `SDE_OFF_CTRL) begin
			next_st.ctrl = apb_in.pwdata[`SDE_CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{ctrl: `SDE_CTRL_RESET, prdata: `SDE_WORD_ZERO};
		end else begin
			st <= next_st;
		end
	end

	assign apb_out.prdata  = st.prdata;
	assign apb_out.pready  = 1'b1;
	assign apb_out.pslverr = apb_in.psel && apb_in.penable && !is_mapped(apb_in.paddr);
	assign ctrl            = st.ctrl;

endmodule

// File: core/sde_data_bp.sv
module sde_data_bp (
	input  wire logic  clk_sys,
	input  wire logic  sys_rst,
	input  wire logic  enable,
	input  wire logic  str_iter,
	input  wire logic  string_input_op,
	input  wire logic  str_data_match,
	input  wire logic  str_done,
	output logic       trap,
	output logic       pending
);

	typedef struct packed {
		logic pend;
		logic trap;
	} dbp_state_t;

	dbp_state_t st;
	dbp_state_t next_st;
	logic       hit;

	// ********************************************************************
	// output strings trap right after the hit, input strings one later
	// ********************************************************************
	always_comb begin
		next_st      = st;
		next_st.trap = 1'b0;
		hit          = enable && str_iter && str_data_match;
		if (st.pend && (str_iter || str_done)) begin
			next_st.trap = 1'b1;
			next_st.pend = 1'b0;
		end
		if (hit && !string_input_op) begin
			next_st.trap = 1'b1;
		end
		// a new input hit wins over the release of an older one
		if (hit && string_input_op) begin
			next_st.pend = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{pend: 1'b0, trap: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign trap    = st.trap;
	assign pending = st.pend;

endmodule

// File: core/sde_event_ctrl.sv
`include "sde_params.svh"

// What this block does
// - hold at most one pending management interrupt while in management mode
// - first request after mode-active is latched, serviced after resume instruction
// - block further nmi during its handler until interrupt return
// - management mode entry drops nmi blocking, so later nmi nests
// - breakpoint on a meaningless prefix byte need not be recognized
// - clear resume flag on return re-raises the breakpoint fault each time
// - breakpoint plus other fault gives one spurious repeat after that fault
// - hardware may set stacked resume flag on fault handler entry
// - output string data breakpoint traps after the hitting iteration
// - input string data breakpoint traps one iteration later
module sde_event_ctrl (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire sde_pkg::apb_in_t    apb_in,
	output sde_pkg::apb_out_t        apb_out,
	input  wire logic                sys_mgmt_irq_n,
	output logic                     mgmt_mode_active_n,
	input  wire sde_pkg::core_ev_t   ev,
	output sde_pkg::core_act_t       act
);

	typedef struct packed {
		logic                    smi_pin_q;
		logic                    smi_pending;
		logic                    in_smm;
		logic                    nmi_pending;
		logic                    nmi_block;
		logic [`SDE_DEPTH_W-1:0] nmi_depth;
		logic [`SDE_NEST_W-1:0]  nest_count;
		logic                    resume_flag;
		logic                    spur_wait;
		logic                    spurious;
		logic                    take_smi;
		logic                    take_nmi;
		logic                    bp_fault;
		logic                    stacked_rf;
	} ctrl_state_t;

	ctrl_state_t              st;
	ctrl_state_t              next_st;
	logic [`SDE_CTRL_W-1:0]   ctrl;
	sde_pkg::status_t         status;
	logic                     smi_req;
	logic                     take_smi;
	logic                     take_nmi;
	logic                     bp_arm;
	logic                     bp_fire;
	logic                     dbp_trap;
	logic                     dbp_pend;
	logic [`SDE_NEST_W-1:0]   depth_inc;

	function automatic logic [`SDE_NEST_W-1:0] sat_inc(input logic [`SDE_NEST_W-1:0] v,
							    input logic [`SDE_NEST_W-1:0] top);
		sat_inc = (v == top) ? v : v + `SDE_NEST_ONE;
	endfunction

	// ********************************************************************
	// register slave and data breakpoint timing
	// ********************************************************************
	sde_apb_regs u_regs (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.apb_in     (apb_in),
		.apb_out    (apb_out),
		.status     (status),
		.nest_count (st.nest_count),
		.ctrl       (ctrl)
	);

	sde_data_bp u_dbp (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.enable          (ctrl[`SDE_CTRL_DBP_EN]),
		.str_iter        (ev.str_iter),
		.string_input_op (ev.string_input_op),
		.str_data_match  (ev.str_data_match),
		.str_done        (ev.str_done),
		.trap            (dbp_trap),
		.pending         (dbp_pend)
	);

	// ********************************************************************
	// event decode
	// ********************************************************************
	always_comb begin
		smi_req  = st.smi_pin_q && !sys_mgmt_irq_n;
		take_smi = st.smi_pending && !st.in_smm;
		// nmi waits while in management mode and loses to a management entry
		take_nmi = st.nmi_pending && !st.nmi_block && !st.in_smm && !take_smi;
		// prefix-byte matches are dropped: bp_arm is masked whenever instr_prefix_match is set
		bp_arm   = ctrl[`SDE_CTRL_BP_EN] && ev.instr_start && ev.instr_bp_match
			   && !ev.instr_prefix_match;
		bp_fire  = bp_arm && (!st.resume_flag || st.spurious);
		// widened so the shared saturating add can serve the narrow depth too
		depth_inc = sat_inc({{(`SDE_NEST_W-`SDE_DEPTH_W){1'b0}}, st.nmi_depth},
				    {{(`SDE_NEST_W-`SDE_DEPTH_W){1'b0}}, {`SDE_DEPTH_W{1'b1}}});
	end

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		next_st           = st;
		next_st.smi_pin_q = sys_mgmt_irq_n;

		// one pending bit: extra requests in management mode merge into it
		if (take_smi) begin
			next_st.smi_pending = 1'b0;
		end
		if (smi_req) begin
			next_st.smi_pending = 1'b1;
		end
		if (take_smi) begin
			next_st.in_smm = 1'b1;
		end else if (ev.resume_from_mgmt_mode) begin
			next_st.in_smm = 1'b0;
		end

		if (take_nmi) begin
			next_st.nmi_pending = 1'b0;
		end
		if (ev.nmi_req) begin
			next_st.nmi_pending = 1'b1;
		end
		if (ev.interrupt_return) begin
			next_st.nmi_block = 1'b0;
		end
		if (take_smi) begin
			next_st.nmi_block = 1'b0;
		end
		if (take_nmi) begin
			next_st.nmi_block = 1'b1;
		end

		// depth counts unfinished handlers so software can see nesting
		if (take_nmi && !ev.interrupt_return) begin
			next_st.nmi_depth = depth_inc[`SDE_DEPTH_W-1:0];
		end else if (!take_nmi && ev.interrupt_return && st.nmi_depth != `SDE_DEPTH_ZERO) begin
			next_st.nmi_depth = st.nmi_depth - `SDE_DEPTH_ONE;
		end
		if (take_nmi && st.nmi_depth != `SDE_DEPTH_ZERO) begin
			next_st.nest_count = sat_inc(st.nest_count, {`SDE_NEST_W{1'b1}});
		end

		if (ev.instr_start) begin
			next_st.resume_flag = 1'b0;
		end
		if (ev.interrupt_return) begin
			next_st.resume_flag = ev.popped_resume_flag;
		end

		// the repeat is armed only once the coinciding fault has been handled
		if (bp_fire && ev.other_fault) begin
			next_st.spur_wait = 1'b1;
		end else if (ev.fault_return && st.spur_wait) begin
			next_st.spur_wait = 1'b0;
		end
		if (bp_arm && st.spurious) begin
			next_st.spurious = 1'b0;
		end else if (ev.fault_return && st.spur_wait) begin
			next_st.spurious = 1'b1;
		end

		next_st.take_smi   = take_smi;
		next_st.take_nmi   = take_nmi;
		next_st.bp_fault   = bp_fire;
		next_st.stacked_rf = ev.other_fault && ctrl[`SDE_CTRL_AUTORF];
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{smi_pin_q: 1'b1, nmi_depth: `SDE_DEPTH_ZERO, nest_count: `SDE_NEST_ZERO, default: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign mgmt_mode_active_n = !st.in_smm;
	assign act.take_smi            = st.take_smi;
	assign act.take_nmi            = st.take_nmi;
	assign act.bp_fault            = st.bp_fault;
	assign act.data_bp_trap        = dbp_trap;
	assign act.stacked_resume_flag = st.stacked_rf;
	assign act.resume_flag         = st.resume_flag;

	assign status.nmi_depth   = st.nmi_depth;
	assign status.spurious    = st.spurious;
	assign status.spur_wait   = st.spur_wait;
	assign status.resume_flag = st.resume_flag;
	assign status.nmi_pending = st.nmi_pending;
	assign status.nmi_block   = st.nmi_block;
	assign status.smi_pending = st.smi_pending;
	assign status.in_smm      = st.in_smm;

	// ********************************************************************
	// assertions
	// ********************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	property p_smi_single;
		act.take_smi |=> !act.take_smi;
	endproperty
	a_smi_single: assert property (p_smi_single) else $error("two management entries back to back");

	property p_smi_merge;
		(st.in_smm && st.smi_pending && smi_req && !ev.resume_from_mgmt_mode) |=> st.smi_pending && st.in_smm;
	endproperty
	a_smi_merge: assert property (p_smi_merge) else $error("pending request lost in mode");

	property p_smi_after_resume;
		(ev.resume_from_mgmt_mode && st.in_smm && st.smi_pending) |-> ##2 (act.take_smi && !mgmt_mode_active_n);
	endproperty
	a_smi_after_resume: assert property (p_smi_after_resume) else $error("latched request not serviced");

	property p_smi_mode;
		act.take_smi |-> !mgmt_mode_active_n;
	endproperty
	a_smi_mode: assert property (p_smi_mode) else $error("mode active not shown on entry");

	property p_nmi_blocked;
		st.nmi_block |=> !act.take_nmi;
	endproperty
	a_nmi_blocked: assert property (p_nmi_blocked) else $error("nmi taken while blocked");

	property p_nmi_sets_block;
		act.take_nmi |-> st.nmi_block;
	endproperty
	a_nmi_sets_block: assert property (p_nmi_sets_block) else $error("nmi taken without blocking");

	property p_smi_drops_block;
		act.take_smi |-> !st.nmi_block;
	endproperty
	a_smi_drops_block: assert property (p_smi_drops_block) else $error("blocking kept over entry");

	property p_prefix_ignored;
		(ev.instr_start && ev.instr_prefix_match) |=> !act.bp_fault;
	endproperty
	a_prefix_ignored: assert property (p_prefix_ignored) else $error("fault on prefix byte");

	property p_bp_refault;
		(bp_arm && !st.resume_flag) |=> act.bp_fault;
	endproperty
	a_bp_refault: assert property (p_bp_refault) else $error("breakpoint not re-raised");

	property p_spurious;
		(ev.fault_return && st.spur_wait && !bp_arm) ##1 bp_arm |=> act.bp_fault;
	endproperty
	a_spurious: assert property (p_spurious) else $error("spurious repeat missing");

	property p_auto_rf;
		(ev.other_fault && ctrl[`SDE_CTRL_AUTORF]) |=> act.stacked_resume_flag;
	endproperty
	a_auto_rf: assert property (p_auto_rf) else $error("stacked resume flag not set");

	property p_out_trap;
		(ctrl[`SDE_CTRL_DBP_EN] && ev.str_iter && ev.str_data_match && !ev.string_input_op) |=> act.data_bp_trap;
	endproperty
	a_out_trap: assert property (p_out_trap) else $error("output string trap late");

	property p_in_trap;
		(ctrl[`SDE_CTRL_DBP_EN] && ev.str_iter && ev.str_data_match && ev.string_input_op)
			##1 (dbp_pend && ev.str_iter) |=> act.data_bp_trap;
	endproperty
	a_in_trap: assert property (p_in_trap) else $error("input string trap not one later");

	property p_rf_one_shot;
		(ev.instr_start && !ev.interrupt_return) |=> !st.resume_flag;
	endproperty
	a_rf_one_shot: assert property (p_rf_one_shot) else $error("resume flag not cleared");

	property p_smi_latch;
		smi_req |=> st.smi_pending;
	endproperty
	a_smi_latch: assert property (p_smi_latch) else $error("request edge not latched");

	property p_smi_take;
		(st.smi_pending && !st.in_smm) |=> (act.take_smi && !mgmt_mode_active_n);
	endproperty
	a_smi_take: assert property (p_smi_take) else $error("pending request not taken");

	property p_smi_hold;
		(st.in_smm && !ev.resume_from_mgmt_mode) |=> (st.in_smm && !act.take_smi);
	endproperty
	a_smi_hold: assert property (p_smi_hold) else $error("request serviced inside the mode");

	property p_smi_exit;
		(ev.resume_from_mgmt_mode && st.in_smm && !st.smi_pending) |=> mgmt_mode_active_n;
	endproperty
	a_smi_exit: assert property (p_smi_exit) else $error("mode not left on resume");

	property p_nmi_release;
		(ev.interrupt_return && !take_nmi) |=> !st.nmi_block;
	endproperty
	a_nmi_release: assert property (p_nmi_release) else $error("blocking kept after return");

	property p_nmi_held;
		(st.nmi_pending && (st.nmi_block || st.in_smm)) |=> st.nmi_pending;
	endproperty
	a_nmi_held: assert property (p_nmi_held) else $error("held nmi request lost");

	property p_nest_count;
		(take_nmi && st.nmi_depth != `SDE_DEPTH_ZERO && st.nest_count != {`SDE_NEST_W{1'b1}})
			|=> (st.nest_count == $past(st.nest_count) + `SDE_NEST_ONE);
	endproperty
	a_nest_count: assert property (p_nest_count) else $error("nested nmi not counted");

	property p_rf_load;
		ev.interrupt_return |=> (st.resume_flag == $past(ev.popped_resume_flag));
	endproperty
	a_rf_load: assert property (p_rf_load) else $error("resume flag not loaded on return");

	property p_rf_masks;
		(bp_arm && st.resume_flag && !st.spurious) |=> !act.bp_fault;
	endproperty
	a_rf_masks: assert property (p_rf_masks) else $error("fault despite resume flag");

	property p_spur_clear;
		(bp_arm && st.spurious) |=> !st.spurious;
	endproperty
	a_spur_clear: assert property (p_spur_clear) else $error("spurious repeat not one shot");

	property p_dbp_off;
		(!ctrl[`SDE_CTRL_DBP_EN] && !dbp_pend) |=> !act.data_bp_trap;
	endproperty
	a_dbp_off: assert property (p_dbp_off) else $error("data trap while disabled");

	property p_in_wait;
		(ctrl[`SDE_CTRL_DBP_EN] && ev.str_iter && ev.str_data_match && ev.string_input_op && !dbp_pend)
			|=> !act.data_bp_trap;
	endproperty
	a_in_wait: assert property (p_in_wait) else $error("input string trap too early");

	c_smi_resume: cover property (ev.resume_from_mgmt_mode && st.smi_pending ##2 act.take_smi);
	c_nmi_nest:   cover property (act.take_nmi && st.nmi_depth > `SDE_DEPTH_ONE);
	c_spurious:   cover property (st.spurious && bp_arm && st.resume_flag);
	c_in_trap:    cover property (dbp_pend ##1 act.data_bp_trap);
	c_smi_merge:  cover property (st.in_smm && st.smi_pending && smi_req);

endmodule

// File: sim/sde_far_side.sv
// ********************************************************************
// far side: system logic on the request pin plus handler software
// ********************************************************************
module sde_far_side (
	input  wire logic          clk_sys,
	output logic               sys_mgmt_irq_n,
	output sde_pkg::core_ev_t  ev
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sys_mgmt_irq_n = 1'b1;
		ev = '0;
	end

	// a request is a falling edge; held low a few cycles so two edges see it
	task automatic smi();
		@(posedge clk_sys);
		sys_mgmt_irq_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		sys_mgmt_irq_n <= 1'b1;
		@(posedge clk_sys);
	endtask

	// one pipeline or handler event, one cycle wide; handlers stay re-entrant for nesting
	task automatic send(input sde_pkg::core_ev_t v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= '0;
	endtask
endmodule

// File: sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************************************************
	// clock, reset, design and far side
	// ********************************************************************
	logic                clk_sys = 1'b0;
	logic                sys_rst = 1'b1;
	sde_pkg::apb_in_t    apb_in = '0;
	sde_pkg::apb_out_t   apb_out;
	logic                sys_mgmt_irq_n;
	logic                mgmt_mode_active_n;
	sde_pkg::core_ev_t   ev;
	sde_pkg::core_act_t  act;
	int                  errors = 0;
	int                  total_checks = 0;
	int                  n_smi = 0;
	int                  n_nmi = 0;
	int                  n_srf = 0;
	logic [31:0]         rd;
	logic                err;

	always #4 clk_sys = ~clk_sys;

	sde_event_ctrl uut (
		.clk_sys            (clk_sys),
		.sys_rst            (sys_rst),
		.apb_in             (apb_in),
		.apb_out            (apb_out),
		.sys_mgmt_irq_n     (sys_mgmt_irq_n),
		.mgmt_mode_active_n (mgmt_mode_active_n),
		.ev                 (ev),
		.act                (act)
	);

	sde_far_side far (
		.clk_sys        (clk_sys),
		.sys_mgmt_irq_n (sys_mgmt_irq_n),
		.ev             (ev)
	);

	// counting pulses keeps the checks free of exact entry latencies
	always @(posedge clk_sys) begin
		if (act.take_smi === 1'b1) n_smi++;
		if (act.take_nmi === 1'b1) n_nmi++;
		if (act.stacked_resume_flag === 1'b1) n_srf++;
	end

	// ********************************************************************
	// shared tasks
	// ********************************************************************
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk_sys);
		apb_in.penable <= 1'b1;
		@(posedge clk_sys);
		while (apb_out.pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				errors++;
				summarize();
			end
			@(posedge clk_sys);
		end
		rd = apb_out.prdata;
		err = apb_out.pslverr;
		apb_in <= '0;
		@(posedge clk_sys);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// ********************************************************************
	// scenarios
	// ********************************************************************
	initial begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, 12'h000, 32'h00000000);
		check("ctrl reset", rd, 32'h00000003);
		apb(1'b1, 12'h000, 32'h00000007);
		apb(1'b0, 12'h000, 32'h00000000);
		check("ctrl rw", rd, 32'h00000007);
		apb(1'b0, 12'h00C, 32'h00000000);
		check("unmapped err", {31'h0, err}, 32'h00000001);

		// one pending request merges the later ones
		far.smi();
		idle(3);
		check("mode active", {31'h0, mgmt_mode_active_n}, 32'h00000000);
		far.smi();
		far.smi();
		apb(1'b0, 12'h004, 32'h00000000);
		check("smi pending", rd & 32'h00000003, 32'h00000003);
		far.send('{resume_from_mgmt_mode: 1'b1, default: 1'b0});
		idle(4);
		check("smi serviced", n_smi, 2);
		far.send('{resume_from_mgmt_mode: 1'b1, default: 1'b0});
		idle(4);
		check("no second queued", n_smi, 2);
		check("mode left", {31'h0, mgmt_mode_active_n}, 32'h00000001);

		// nmi blocked until return, then nested after a management excursion
		far.send('{nmi_req: 1'b1, default: 1'b0});
		idle(3);
		far.send('{nmi_req: 1'b1, default: 1'b0});
		idle(3);
		check("nmi blocked", n_nmi, 1);
		far.send('{interrupt_return: 1'b1, default: 1'b0});
		idle(3);
		check("nmi after return", n_nmi, 2);
		far.smi();
		idle(3);
		far.send('{nmi_req: 1'b1, default: 1'b0});
		idle(3);
		check("nmi held in mode", n_nmi, 2);
		far.send('{resume_from_mgmt_mode: 1'b1, default: 1'b0});
		idle(4);
		check("nmi nests", n_nmi, 3);
		apb(1'b0, 12'h008, 32'h00000000);
		check("nest count", rd, 32'h00000001);
		far.send('{interrupt_return: 1'b1, default: 1'b0});
		far.send('{interrupt_return: 1'b1, default: 1'b0});

		// instruction breakpoints and the resume flag
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, default: 1'b0});
		#1 check("bp fault", act.bp_fault, 1);
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, default: 1'b0});
		#1 check("bp repeats", act.bp_fault, 1);
		far.send('{interrupt_return: 1'b1, popped_resume_flag: 1'b1, default: 1'b0});
		#1 check("rf loaded", act.resume_flag, 1);
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, default: 1'b0});
		#1 check("rf masks one", act.bp_fault, 0);
		check("rf cleared", act.resume_flag, 0);
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, default: 1'b0});
		#1 check("bp after rf", act.bp_fault, 1);
		// breakpoint on a meaningless prefix, placed there on purpose
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, instr_prefix_match: 1'b1, default: 1'b0});
		#1 check("prefix ignored", act.bp_fault, 0);

		// breakpoint with a second fault gives one spurious repeat
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, other_fault: 1'b1, default: 1'b0});
		idle(3);
		check("auto stacked rf", n_srf, 1);
		far.send('{interrupt_return: 1'b1, popped_resume_flag: 1'b1, default: 1'b0});
		far.send('{fault_return: 1'b1, default: 1'b0});
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, default: 1'b0});
		#1 check("spurious repeat", act.bp_fault, 1);

		// data breakpoints in string loops
		far.send('{str_iter: 1'b1, str_data_match: 1'b1, default: 1'b0});
		#1 check("out trap", act.data_bp_trap, 1);
		far.send('{str_iter: 1'b1, string_input_op: 1'b1, str_data_match: 1'b1, default: 1'b0});
		#1 check("in not yet", act.data_bp_trap, 0);
		far.send('{str_iter: 1'b1, string_input_op: 1'b1, default: 1'b0});
		#1 check("in one later", act.data_bp_trap, 1);

		// all control bits off: no fault, no trap, no stacked flag
		idle(1);
		apb(1'b1, 12'h000, 32'h00000000);
		far.send('{instr_start: 1'b1, instr_bp_match: 1'b1, other_fault: 1'b1, str_iter: 1'b1,
			   str_data_match: 1'b1, default: 1'b0});
		#1 check("bp disabled", act.bp_fault, 0);
		check("dbp disabled", act.data_bp_trap, 0);
		idle(3);
		check("auto rf off", n_srf, 1);
		idle(2);
		summarize();
	end
endmodule
